/* logic/ucsi_pkg.sv */
/*
 Shared constants and carriers for the serial channel control block.
 Assumes one 25 MHz clock and a register window of eight words.
*/
package ucsi_pkg;
	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [2:0] IDX_DATA = 3'h0;
	localparam logic [2:0] IDX_MASK = 3'h1;
	localparam logic [2:0] IDX_ID = 3'h2;
	localparam logic [2:0] IDX_FMT = 3'h3;
	localparam logic [2:0] IDX_MCTL = 3'h4;
	localparam logic [2:0] IDX_LINE = 3'h5;
	localparam logic [2:0] IDX_MSTAT = 3'h6;
	localparam logic [2:0] IDX_SCR = 3'h7;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int FMT_WLEN = 0;
	localparam int FMT_STOP = 2;
	localparam int FMT_PAR = 3;
	localparam int FMT_EVEN = 4;
	localparam int FMT_STICK = 5;
	localparam int FMT_BRK = 6;
	localparam int FMT_DLAB = 7;
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_RI = 2;
	localparam int MC_OUT = 3;
	localparam int MC_LOOP = 4;
	localparam int IM_RX = 0;
	localparam int IM_TX = 1;
	localparam int IM_LS = 2;
	localparam int IM_MS = 3;
	// ----------------------------------------
	// Reset values and identification codes
	// ----------------------------------------
	localparam logic [7:0] FMT_RST = 8'h00;
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic [4:0] MCTL_RST = 5'h00;
	localparam logic [7:0] SCR_RST = 8'hff;
	localparam logic [15:0] DIV_RST = 16'h0001;
	localparam logic [7:0] ID_NONE = 8'h01;
	localparam logic [7:0] ID_LS = 8'h06;
	localparam logic [7:0] ID_RX = 8'h04;
	localparam logic [7:0] ID_TX = 8'h02;
	localparam logic [7:0] ID_MS = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	// ----------------------------------------
	// Oversampling counts, in 16x ticks
	// ----------------------------------------
	localparam logic [5:0] BIT_LAST = 6'h0f;
	localparam logic [5:0] START_MID = 6'h07;
	localparam logic [5:0] STOP_1 = 6'h0f;
	localparam logic [5:0] STOP_15 = 6'h17;
	localparam logic [5:0] STOP_2 = 6'h1f;
	// ----------------------------------------
	// Carriers and states
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] wlen;
		logic stop2;
		logic par_en;
		logic even;
		logic stick;
	} ucsi_fmt_s;
	typedef struct packed {
		logic [7:0] data;
		logic pe;
		logic fe;
		logic brk;
	} ucsi_rx_s;
	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_START = 5'h02,
		S_DATA = 5'h04,
		S_PAR = 5'h08,
		S_STOP = 5'h10
	} ucsi_state_e;
endpackage

/* logic/ucsi_tx.sv */
/*
 Serial transmit shifter: start, data LSB first, optional parity, stops.
 Assumes a one-cycle 16x tick and a load only while not busy.
*/
`timescale 1ns/10ps
module ucsi_tx (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic load_i,
	input wire logic [7:0] data_i,
	input wire ucsi_pkg::ucsi_fmt_s fmt_i,
	output logic line_o,
	output logic busy_o
);
	ucsi_pkg::ucsi_state_e state;
	logic [7:0] tx_shift_reg;
	logic [5:0] cnt;
	logic [2:0] bitn;
	logic par;
	logic adv;
	logic [5:0] stop_last;
	logic [7:0] masked;
	logic [2:0] last_bit;

	assign last_bit = {1'b0, fmt_i.wlen} + 3'h4;
	assign masked = data_i & (8'hff >> (2'h3 - fmt_i.wlen));
	assign stop_last = !fmt_i.stop2 ? ucsi_pkg::STOP_1 :
		(fmt_i.wlen == 2'h0 ? ucsi_pkg::STOP_15 : ucsi_pkg::STOP_2);
	assign adv = tick_i && (cnt == (state == ucsi_pkg::S_STOP ? stop_last : ucsi_pkg::BIT_LAST));
	assign busy_o = state != ucsi_pkg::S_IDLE;

	always_ff @(posedge clock_i) begin
		if (rst_i || state == ucsi_pkg::S_IDLE || adv) begin
			cnt <= 6'h00;
		end else if (tick_i) begin
			cnt <= cnt + 6'h01;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state <= ucsi_pkg::S_IDLE;
			tx_shift_reg <= 8'h00;
			bitn <= 3'h0;
			par <= 1'b0;
		end else begin
			case (state)
			ucsi_pkg::S_IDLE: if (load_i) begin
				tx_shift_reg <= masked;
				// Stick parity holds the inverse of the even bit
				par <= fmt_i.stick ? ~fmt_i.even : (fmt_i.even ? ^masked : ~^masked);
				bitn <= 3'h0;
				state <= ucsi_pkg::S_START;
			end
			ucsi_pkg::S_START: if (adv) begin
				state <= ucsi_pkg::S_DATA;
			end
			ucsi_pkg::S_DATA: if (adv) begin
				tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
				bitn <= bitn + 3'h1;
				if (bitn == last_bit) begin
					state <= fmt_i.par_en ? ucsi_pkg::S_PAR : ucsi_pkg::S_STOP;
				end
			end
			ucsi_pkg::S_PAR: if (adv) begin
				state <= ucsi_pkg::S_STOP;
			end
			ucsi_pkg::S_STOP: if (adv) begin
				state <= ucsi_pkg::S_IDLE;
			end
			default: state <= ucsi_pkg::S_IDLE;
			endcase
		end
	end

	always_comb begin
		case (state)
		ucsi_pkg::S_START: line_o = 1'b0;
		ucsi_pkg::S_DATA: line_o = tx_shift_reg[0];
		ucsi_pkg::S_PAR: line_o = par;
		default: line_o = 1'b1;
		endcase
	end
endmodule

/* logic/ucsi_rx.sv */
/*
 Serial receive shifter with start validation at mid bit.
 Assumes the line is synchronous to the clock and a one-cycle 16x tick.
*/
`timescale 1ns/10ps
module ucsi_rx (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic line_i,
	input wire ucsi_pkg::ucsi_fmt_s fmt_i,
	output logic done_o,
	output ucsi_pkg::ucsi_rx_s res_o
);
	ucsi_pkg::ucsi_state_e state;
	logic [7:0] rx_shift_reg;
	logic [5:0] cnt;
	logic [2:0] bitn;
	logic pbit;
	logic adv;
	logic [7:0] word;
	logic expect_par;

	assign word = rx_shift_reg >> (2'h3 - fmt_i.wlen);
	assign expect_par = fmt_i.stick ? ~fmt_i.even : (fmt_i.even ? ^word : ~^word);
	assign adv = tick_i && (cnt == (state == ucsi_pkg::S_START ? ucsi_pkg::START_MID : ucsi_pkg::BIT_LAST));

	always_ff @(posedge clock_i) begin
		if (rst_i || state == ucsi_pkg::S_IDLE || adv) begin
			cnt <= 6'h00;
		end else if (tick_i) begin
			cnt <= cnt + 6'h01;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state <= ucsi_pkg::S_IDLE;
			rx_shift_reg <= 8'h00;
			bitn <= 3'h0;
			pbit <= 1'b0;
			done_o <= 1'b0;
			res_o <= '0;
		end else begin
			done_o <= 1'b0;
			case (state)
			ucsi_pkg::S_IDLE: if (tick_i && !line_i) begin
				state <= ucsi_pkg::S_START;
			end
			// A glitch shorter than half a bit is dropped here
			ucsi_pkg::S_START: if (adv) begin
				state <= line_i ? ucsi_pkg::S_IDLE : ucsi_pkg::S_DATA;
				bitn <= 3'h0;
			end
			ucsi_pkg::S_DATA: if (adv) begin
				rx_shift_reg <= {line_i, rx_shift_reg[7:1]};
				bitn <= bitn + 3'h1;
				if (bitn == {1'b0, fmt_i.wlen} + 3'h4) begin
					state <= fmt_i.par_en ? ucsi_pkg::S_PAR : ucsi_pkg::S_STOP;
				end
			end
			ucsi_pkg::S_PAR: if (adv) begin
				pbit <= line_i;
				state <= ucsi_pkg::S_STOP;
			end
			ucsi_pkg::S_STOP: if (adv) begin
				done_o <= 1'b1;
				res_o.data <= word;
				res_o.pe <= fmt_i.par_en && (pbit != expect_par);
				res_o.fe <= !line_i;
				res_o.brk <= (word == 8'h00) && !line_i && !(fmt_i.par_en && pbit);
				state <= ucsi_pkg::S_IDLE;
			end
			default: state <= ucsi_pkg::S_IDLE;
			endcase
		end
	end
endmodule

/* logic/ucsi_core.sv */
/*
 One serial channel: register file on AXI4-Lite, interrupt priority,
 frame format, modem control with loop-back and line status.
 Assumes all pins are synchronous to clock_i and a single master.
*/
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
// Function
// - Receive-ready interrupt follows holding register full
// - Transmit-empty interrupt while holding register empty
// - Mask bit two gates line status
// - Mask bit three gates modem; upper zero
// - Identification shows highest source, fixed codes
// - Identification read clears only reported source
// - Two format bits pick 5-8 bit length
// - Format bit two picks 1, 1.5, 2 stops
// - Format bit three enables parity send/check
// - Format bit four picks odd or even
// - Format bit five forces parity value
// - Format bit six holds line low
// - Format bit seven redirects to divisor
// - Modem bits zero, one drive low outputs
// - Modem bit three enables interrupt driver
// - Modem bit four loops back, mapping inputs
// - Line bit zero shows received data
// - Overrun flags, holding register left untouched
// - Line bits two, three flag parity/framing
// - Line bit four flags full-frame break
// - Line bit five shows holding empty
// - Line bit six shows transmitter idle
// - Modem changes flag modem interrupt, bell input only on its rise
// - Divisor bytes at indices zero, one
module ucsi_core (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [4:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [4:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	input wire logic rx_i,
	output logic tx_o,
	input wire logic cts_n_i,
	input wire logic dsr_n_i,
	input wire logic bell_signal_in_n_i,
	input wire logic carrier_sense_in_n_i,
	output logic dtr_n_o,
	output logic rts_n_o,
	output logic irq_o,
	output logic irq_oe_o
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [3:0] irq_mask_reg;
	logic [7:0] frame_format_reg;
	logic [4:0] modem_ctrl_reg;
	logic [7:0] scratch;
	logic [15:0] divisor;
	logic [7:0] tx_hold_reg;
	logic [7:0] rx_hold_reg;
	logic thr_empty;
	logic tx_ack;
	logic dr;
	logic oe;
	logic pe;
	logic fe;
	logic brk;
	logic ls_pend;
	logic ms_pend;
	logic [3:0] mdm_prev;
	logic [3:0] delta;
	logic [15:0] baud_cnt;
	logic tick;
	logic [4:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wstrb_q;
	logic aw_ok;
	logic w_ok;

	// ----------------------------------------
	// Decode and derived state
	// ----------------------------------------
	ucsi_pkg::ucsi_fmt_s fmt;
	ucsi_pkg::ucsi_rx_s rx_res;
	logic dlab;
	logic loop;
	logic wr;
	logic [2:0] wr_idx;
	logic rd;
	logic [2:0] rd_idx;
	logic wr_thr;
	logic rd_rhr;
	logic rd_id;
	logic rd_lsr;
	logic rd_msr;
	logic tx_line;
	logic tx_int;
	logic tx_busy;
	logic tx_load;
	logic rx_line;
	logic rx_done;
	logic ls_src;
	logic rx_src;
	logic tx_src;
	logic ms_src;
	logic any_pend;
	logic [7:0] id_code;
	logic [7:0] line_state_reg;
	logic [3:0] mdm_now;
	logic [3:0] delta_ev;
	logic [7:0] rd_val;
	logic err_ev;

	assign dlab = frame_format_reg[ucsi_pkg::FMT_DLAB];
	assign loop = modem_ctrl_reg[ucsi_pkg::MC_LOOP];
	assign fmt.wlen = frame_format_reg[ucsi_pkg::FMT_WLEN+:2];
	assign fmt.stop2 = frame_format_reg[ucsi_pkg::FMT_STOP];
	assign fmt.par_en = frame_format_reg[ucsi_pkg::FMT_PAR];
	assign fmt.even = frame_format_reg[ucsi_pkg::FMT_EVEN];
	assign fmt.stick = frame_format_reg[ucsi_pkg::FMT_STICK];

	assign wr_idx = awaddr_q[4:2];
	assign wr = aw_ok && w_ok && !bvalid_o && wstrb_q;
	assign rd_idx = araddr_i[4:2];
	assign rd = arvalid_i && arready_o;
	assign wr_thr = wr && wr_idx == ucsi_pkg::IDX_DATA && !dlab;
	assign rd_rhr = rd && rd_idx == ucsi_pkg::IDX_DATA && !dlab;
	assign rd_id = rd && rd_idx == ucsi_pkg::IDX_ID;
	assign rd_lsr = rd && rd_idx == ucsi_pkg::IDX_LINE;
	assign rd_msr = rd && rd_idx == ucsi_pkg::IDX_MSTAT;

	// Break forces the shifter output low; loop-back sees it too
	assign tx_int = frame_format_reg[ucsi_pkg::FMT_BRK] ? 1'b0 : tx_line;
	assign rx_line = loop ? tx_int : rx_i;
	assign tx_load = !thr_empty && !tx_busy;

	// Bit order: 3 carrier, 2 bell, 1 data set ready, 0 clear to send
	assign mdm_now = loop ? ~{modem_ctrl_reg[ucsi_pkg::MC_OUT], modem_ctrl_reg[ucsi_pkg::MC_RI],
		modem_ctrl_reg[ucsi_pkg::MC_DTR], modem_ctrl_reg[ucsi_pkg::MC_RTS]} :
		{carrier_sense_in_n_i, bell_signal_in_n_i, dsr_n_i, cts_n_i};
	assign delta_ev = {mdm_prev[3] ^ mdm_now[3], !mdm_prev[2] && mdm_now[2],
		mdm_prev[1] ^ mdm_now[1], mdm_prev[0] ^ mdm_now[0]};

	assign err_ev = rx_done && ((dr && !rd_rhr) || rx_res.pe || rx_res.fe || rx_res.brk);
	assign line_state_reg = {1'b0, thr_empty && !tx_busy, thr_empty, brk, fe, pe, oe, dr};

	assign ls_src = irq_mask_reg[ucsi_pkg::IM_LS] && ls_pend;
	assign rx_src = irq_mask_reg[ucsi_pkg::IM_RX] && dr;
	assign tx_src = irq_mask_reg[ucsi_pkg::IM_TX] && thr_empty && !tx_ack;
	assign ms_src = irq_mask_reg[ucsi_pkg::IM_MS] && ms_pend;
	assign any_pend = ls_src || rx_src || tx_src || ms_src;

	always_comb begin
		if (ls_src) begin
			id_code = ucsi_pkg::ID_LS;
		end else if (rx_src) begin
			id_code = ucsi_pkg::ID_RX;
		end else if (tx_src) begin
			id_code = ucsi_pkg::ID_TX;
		end else if (ms_src) begin
			id_code = ucsi_pkg::ID_MS;
		end else begin
			id_code = ucsi_pkg::ID_NONE;
		end
	end

	always_comb begin
		if (rd_idx == ucsi_pkg::IDX_DATA) begin
			rd_val = dlab ? divisor[7:0] : rx_hold_reg;
		end else if (rd_idx == ucsi_pkg::IDX_MASK) begin
			rd_val = dlab ? divisor[15:8] : {4'h0, irq_mask_reg};
		end else if (rd_idx == ucsi_pkg::IDX_ID) begin
			rd_val = id_code;
		end else if (rd_idx == ucsi_pkg::IDX_FMT) begin
			rd_val = frame_format_reg;
		end else if (rd_idx == ucsi_pkg::IDX_MCTL) begin
			rd_val = {3'h0, modem_ctrl_reg};
		end else if (rd_idx == ucsi_pkg::IDX_LINE) begin
			rd_val = line_state_reg;
		end else if (rd_idx == ucsi_pkg::IDX_MSTAT) begin
			rd_val = {~mdm_now, delta};
		end else begin
			rd_val = scratch;
		end
	end

	// ----------------------------------------
	// AXI4-Lite write and read channels
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			awready_o <= 1'b1;
			wready_o <= 1'b1;
			aw_ok <= 1'b0;
			w_ok <= 1'b0;
			awaddr_q <= 5'h00;
			wdata_q <= 8'h00;
			wstrb_q <= 1'b0;
			bvalid_o <= 1'b0;
			bresp_o <= ucsi_pkg::RESP_OKAY;
		end else begin
			if (awvalid_i && awready_o) begin
				awaddr_q <= awaddr_i;
				aw_ok <= 1'b1;
				awready_o <= 1'b0;
			end
			if (wvalid_i && wready_o) begin
				wdata_q <= wdata_i[7:0];
				wstrb_q <= wstrb_i[0];
				w_ok <= 1'b1;
				wready_o <= 1'b0;
			end
			if (aw_ok && w_ok && !bvalid_o) begin
				bvalid_o <= 1'b1;
			end
			if (bvalid_o && bready_i) begin
				bvalid_o <= 1'b0;
				aw_ok <= 1'b0;
				w_ok <= 1'b0;
				awready_o <= 1'b1;
				wready_o <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			arready_o <= 1'b1;
			rvalid_o <= 1'b0;
			rdata_o <= 32'h00000000;
			rresp_o <= ucsi_pkg::RESP_OKAY;
		end else if (rd) begin
			arready_o <= 1'b0;
			rvalid_o <= 1'b1;
			rdata_o <= {24'h000000, rd_val};
		end else if (rvalid_o && rready_i) begin
			rvalid_o <= 1'b0;
			arready_o <= 1'b1;
		end
	end

	// ----------------------------------------
	// Software-written registers
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			irq_mask_reg <= ucsi_pkg::MASK_RST;
			frame_format_reg <= ucsi_pkg::FMT_RST;
			modem_ctrl_reg <= ucsi_pkg::MCTL_RST;
			scratch <= ucsi_pkg::SCR_RST;
			divisor <= ucsi_pkg::DIV_RST;
			tx_hold_reg <= 8'h00;
		end else if (wr) begin
			if (wr_idx == ucsi_pkg::IDX_DATA) begin
				if (dlab) begin
					divisor[7:0] <= wdata_q;
				end else begin
					tx_hold_reg <= wdata_q;
				end
			end else if (wr_idx == ucsi_pkg::IDX_MASK) begin
				if (dlab) begin
					divisor[15:8] <= wdata_q;
				end else begin
					irq_mask_reg <= wdata_q[3:0];
				end
			end else if (wr_idx == ucsi_pkg::IDX_FMT) begin
				frame_format_reg <= wdata_q;
			end else if (wr_idx == ucsi_pkg::IDX_MCTL) begin
				modem_ctrl_reg <= wdata_q[4:0];
			end else if (wr_idx == ucsi_pkg::IDX_SCR) begin
				scratch <= wdata_q;
			end
		end
	end

	// ----------------------------------------
	// Baud tick at 16x the bit rate
	// ----------------------------------------
	// A zero divisor stops the tick, which freezes the receiver; the transmitter still loads and then stops in its start bit
	always_ff @(posedge clock_i) begin
		if (rst_i || divisor == 16'h0000) begin
			baud_cnt <= 16'h0000;
			tick <= 1'b0;
		end else if (baud_cnt >= divisor - 16'h0001) begin
			baud_cnt <= 16'h0000;
			tick <= 1'b1;
		end else begin
			baud_cnt <= baud_cnt + 16'h0001;
			tick <= 1'b0;
		end
	end

	// ----------------------------------------
	// Transmit path
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			thr_empty <= 1'b1;
			tx_ack <= 1'b0;
		end else begin
			if (wr_thr) begin
				thr_empty <= 1'b0;
			end else if (tx_load) begin
				thr_empty <= 1'b1;
			end
			if (rd_id && id_code == ucsi_pkg::ID_TX) begin
				tx_ack <= 1'b1;
			end else if (wr_thr) begin
				tx_ack <= 1'b0;
			end
		end
	end

	ucsi_tx u_tx (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.tick_i(tick),
		.load_i(tx_load),
		.data_i(tx_hold_reg),
		.fmt_i(fmt),
		.line_o(tx_line),
		.busy_o(tx_busy)
	);

	// ----------------------------------------
	// Receive path and line status
	// ----------------------------------------
	ucsi_rx u_rx (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.tick_i(tick),
		.line_i(rx_line),
		.fmt_i(fmt),
		.done_o(rx_done),
		.res_o(rx_res)
	);

	// A new character always wins over a clearing read
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rx_hold_reg <= 8'h00;
			dr <= 1'b0;
			oe <= 1'b0;
		end else begin
			if (rx_done && dr && !rd_rhr) begin
				oe <= 1'b1;
			end else if (rd_lsr) begin
				oe <= 1'b0;
			end
			if (rx_done && !(dr && !rd_rhr)) begin
				rx_hold_reg <= rx_res.data;
				dr <= 1'b1;
			end else if (rd_rhr) begin
				dr <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pe <= 1'b0;
			fe <= 1'b0;
			brk <= 1'b0;
			ls_pend <= 1'b0;
		end else begin
			pe <= (rx_done && rx_res.pe) || (pe && !rd_lsr);
			fe <= (rx_done && rx_res.fe) || (fe && !rd_lsr);
			brk <= (rx_done && rx_res.brk) || (brk && !rd_lsr);
			ls_pend <= err_ev || (ls_pend && !rd_lsr && !(rd_id && id_code == ucsi_pkg::ID_LS));
		end
	end

	// ----------------------------------------
	// Modem state changes
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			mdm_prev <= 4'hf;
			delta <= 4'h0;
			ms_pend <= 1'b0;
		end else begin
			mdm_prev <= mdm_now;
			delta <= delta_ev | (rd_msr ? 4'h0 : delta);
			ms_pend <= (|delta_ev) || (ms_pend && !rd_msr && !(rd_id && id_code == ucsi_pkg::ID_MS));
		end
	end

	// ----------------------------------------
	// Pin outputs
	// ----------------------------------------
	// Loop-back parks the line and modem outputs at their idle level
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tx_o <= 1'b1;
			dtr_n_o <= 1'b1;
			rts_n_o <= 1'b1;
			irq_o <= 1'b0;
			irq_oe_o <= 1'b0;
		end else begin
			tx_o <= loop ? 1'b1 : tx_int;
			dtr_n_o <= loop ? 1'b1 : !modem_ctrl_reg[ucsi_pkg::MC_DTR];
			rts_n_o <= loop ? 1'b1 : !modem_ctrl_reg[ucsi_pkg::MC_RTS];
			irq_o <= any_pend && modem_ctrl_reg[ucsi_pkg::MC_OUT];
			irq_oe_o <= modem_ctrl_reg[ucsi_pkg::MC_OUT];
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	isr_idle_a: assert property (!any_pend |-> id_code == 8'h01) else $error("idle id wrong");
	ls_mask_a: assert property (!irq_mask_reg[2] |-> id_code != 8'h06) else $error("masked line status");
	rx_prio_a: assert property (rx_src && !ls_src |-> id_code == 8'h04) else $error("rx id wrong");
	irq_pin_a: assert property (any_pend && modem_ctrl_reg[3] |=> irq_o && irq_oe_o) else $error("irq not driven");
	irq_float_a: assert property (!modem_ctrl_reg[3] |=> !irq_oe_o && !irq_o) else $error("irq not floated");
	break_hold_a: assert property ((frame_format_reg[6] && !loop) [*2] |=> !tx_o) else $error("break not low");
	dtr_drive_a: assert property (modem_ctrl_reg[0] && !loop |=> !dtr_n_o) else $error("dtr not low");
	overrun_keep_a: assert property (rx_done && dr && !rd_rhr |=> oe && $stable(rx_hold_reg)) else $error("overrun");
	data_ready_a: assert property (rx_done && !dr |=> dr && rx_hold_reg == $past(rx_res.data)) else $error("dr");
	temt_thre_a: assert property (line_state_reg[6] |-> line_state_reg[5] && !tx_busy) else $error("empty flags");
	id_clear_a: assert property (rd_id && id_code == 8'h02 |=> !tx_src) else $error("tx id not cleared");

	cover property (rx_done && dr);
	cover property (id_code == 8'h06 && rx_src);
	cover property (loop && rx_done);
	cover property (rd_id && id_code == 8'h00);
endmodule

/* verification/ucsi_remote.sv */
/*
 Remote serial device model that sends frames into the receive pin.
 Assumes the caller is at a rising edge and divisor 1 (16 clocks a bit).
*/
`timescale 1ns/10ps
module ucsi_remote (
	input wire logic clock_i,
	output logic line_o
);
	// ----------------------------------------
	// Frame sender
	// ----------------------------------------
	initial line_o = 1'b1;
	// Bits go out from bit 0 upward; the line returns to idle high after
	task automatic send(input logic [11:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			line_o <= f[i];
			repeat (16) @(posedge clock_i);
		end
		line_o <= 1'b1;
		@(posedge clock_i);
	endtask
endmodule

/* verification/tb_uart_control_status_irq.sv */
/*
 Self-checking bench for the serial channel control block.
 Assumes divisor reset value 1 and registers at byte address 4 * index.
*/
`timescale 1ns/10ps
module tb_uart_control_status_irq;
	logic clock_i = 0, rst_i = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [4:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic awready, wready, bvalid, arready, rvalid, tx, dtr_n, rts_n, irq, irq_oe, rxl;
	logic [7:0] v;
	logic [9:0] f;
	int fail_count = 0, samples_checked = 0, n;
	always #20 clock_i = ~clock_i;
	ucsi_core DUT (.clock_i(clock_i), .rst_i(rst_i), .awaddr_i(awaddr), .awvalid_i(awvalid),
		.awready_o(awready), .wdata_i(wdata), .wstrb_i(4'h1), .wvalid_i(wvalid), .wready_o(wready),
		.bresp_o(), .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
		.arready_o(arready), .rdata_o(rdata), .rresp_o(), .rvalid_o(rvalid), .rready_i(rready),
		.rx_i(rxl), .tx_o(tx), .cts_n_i(1'b1), .dsr_n_i(1'b1), .bell_signal_in_n_i(1'b1),
		.carrier_sense_in_n_i(1'b1), .dtr_n_o(dtr_n), .rts_n_o(rts_n), .irq_o(irq), .irq_oe_o(irq_oe));
	ucsi_remote peer (.clock_i(clock_i), .line_o(rxl));
	// ----------------------------------------
	// Bus tasks and compare
	// ----------------------------------------
	task stop_test();
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [2:0] i, input logic [7:0] d);
		logic a, w;
		a = 0;
		w = 0;
		awaddr <= {i, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(a && w)) begin
			@(posedge clock_i);
			a = a | (awready === 1'b1);
			w = w | (wready === 1'b1);
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1) @(posedge clock_i);
		bready <= 1'b0;
		@(posedge clock_i);
	endtask
	task rd(input logic [2:0] i, output logic [7:0] d);
		araddr <= {i, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clock_i);
		d = rdata[7:0];
		rready <= 1'b0;
		@(posedge clock_i);
	endtask
	task rdc(input logic [2:0] i, input logic [7:0] e);
		logic [7:0] d;
		rd(i, d);
		chk(d, e);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clock_i);
		rst_i <= 1'b0;
		rdc(ucsi_pkg::IDX_MASK, 8'h00);
		rdc(ucsi_pkg::IDX_ID, 8'h01);
		rdc(ucsi_pkg::IDX_FMT, 8'h00);
		rdc(ucsi_pkg::IDX_LINE, 8'h60);
		chk({5'h0, dtr_n, rts_n, irq_oe}, 8'h06);
		wr(ucsi_pkg::IDX_MASK, 8'hff);
		rdc(ucsi_pkg::IDX_MASK, 8'h0f);
		wr(ucsi_pkg::IDX_MCTL, 8'hff);
		rdc(ucsi_pkg::IDX_MCTL, 8'h1f);
		wr(ucsi_pkg::IDX_MCTL, 8'h0b);
		repeat (2) @(posedge clock_i);
		chk({5'h0, dtr_n, rts_n, irq_oe}, 8'h01);
		wr(ucsi_pkg::IDX_FMT, 8'h03);
		wr(ucsi_pkg::IDX_MASK, 8'h03);
		// Frame on the wire sampled mid-bit from the falling start edge
		wr(ucsi_pkg::IDX_DATA, 8'ha5);
		n = 0;
		while (tx !== 1'b0 && n < 100) begin
			@(posedge clock_i);
			n++;
		end
		repeat (8) @(posedge clock_i);
		f = {1'b1, 8'ha5, 1'b0};
		for (int i = 0; i < 10; i++) begin
			chk({7'h0, tx}, {7'h0, f[i]});
			repeat (16) @(posedge clock_i);
		end
		peer.send({2'h1, 8'h3c, 1'b0}, 10);
		repeat (4) @(posedge clock_i);
		chk({7'h0, irq}, 8'h01);
		rdc(ucsi_pkg::IDX_ID, 8'h04);
		rdc(ucsi_pkg::IDX_LINE, 8'h61);
		rdc(ucsi_pkg::IDX_DATA, 8'h3c);
		rdc(ucsi_pkg::IDX_ID, 8'h02);
		rdc(ucsi_pkg::IDX_ID, 8'h01);
		// Odd parity with a wrong parity bit
		wr(ucsi_pkg::IDX_FMT, 8'h0b);
		wr(ucsi_pkg::IDX_MASK, 8'h05);
		peer.send({2'h1, 1'b0, 8'h3c, 1'b0}, 11);
		repeat (4) @(posedge clock_i);
		rdc(ucsi_pkg::IDX_ID, 8'h06);
		rdc(ucsi_pkg::IDX_LINE, 8'h65);
		rdc(ucsi_pkg::IDX_ID, 8'h04);
		rdc(ucsi_pkg::IDX_DATA, 8'h3c);
		// Second word while the first is unread
		wr(ucsi_pkg::IDX_FMT, 8'h03);
		peer.send({2'h1, 8'h11, 1'b0}, 10);
		peer.send({2'h1, 8'h22, 1'b0}, 10);
		repeat (4) @(posedge clock_i);
		rdc(ucsi_pkg::IDX_LINE, 8'h63);
		rdc(ucsi_pkg::IDX_DATA, 8'h11);
		peer.send(12'h000, 10);
		repeat (4) @(posedge clock_i);
		rd(ucsi_pkg::IDX_LINE, v);
		chk(v & 8'h10, 8'h10);
		rdc(ucsi_pkg::IDX_DATA, 8'h00);
		wr(ucsi_pkg::IDX_FMT, 8'h43);
		repeat (40) @(posedge clock_i);
		chk({7'h0, tx}, 8'h00);
		wr(ucsi_pkg::IDX_FMT, 8'h03);
		repeat (3) @(posedge clock_i);
		chk({7'h0, tx}, 8'h01);
		// Forced zero parity on a word whose even parity would be one
		wr(ucsi_pkg::IDX_FMT, 8'h3b);
		peer.send({2'h1, 1'b0, 8'h3d, 1'b0}, 11);
		repeat (4) @(posedge clock_i);
		rdc(ucsi_pkg::IDX_LINE, 8'h61);
		rdc(ucsi_pkg::IDX_DATA, 8'h3d);
		// Loop-back entry and exit left all four change bits set
		wr(ucsi_pkg::IDX_MASK, 8'h08);
		rdc(ucsi_pkg::IDX_ID, 8'h00);
		rdc(ucsi_pkg::IDX_MSTAT, 8'h0f);
		rdc(ucsi_pkg::IDX_ID, 8'h01);
		wr(ucsi_pkg::IDX_FMT, 8'h83);
		wr(ucsi_pkg::IDX_DATA, 8'h02);
		rdc(ucsi_pkg::IDX_DATA, 8'h02);
		rdc(ucsi_pkg::IDX_MASK, 8'h00);
		wr(ucsi_pkg::IDX_DATA, 8'h01);
		wr(ucsi_pkg::IDX_FMT, 8'h03);
		rdc(ucsi_pkg::IDX_MASK, 8'h08);
		rdc(ucsi_pkg::IDX_LINE, 8'h60);
		stop_test();
	end
	// ----------------------------------------
	// Watchdog, well beyond the fewer than 1500 cycles the tests take
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clock_i);
		fail_count++;
		$display("BAD %0t watchdog expired", $time);
		stop_test();
	end
endmodule
